// ### tfe_event_unit.sv
`timescale 1ns/1ps

module tfe_event_unit (
  input  wire logic                          clock_i,
  input  wire logic                          reset_n_i,
  input  wire logic [tfe_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [tfe_pkg::DATA_W-1:0]    wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [tfe_pkg::DATA_W-1:0]    rdata_o,
  input  wire logic                          temp_ok_i,
  input  wire logic                          loop_lock_i,
  input  wire logic                          adc_frame_clock_i,
  output logic                               irq_o,
  output logic      [tfe_pkg::PIN_COUNT-1:0] pin_out_o,
  output logic      [tfe_pkg::PIN_COUNT-1:0] pin_oe_o,
  output logic      [tfe_pkg::PIN_COUNT-1:0] pin_pull_up_o,
  output logic      [tfe_pkg::PIN_COUNT-1:0] pin_pull_down_o,
  output logic                               thermal_sensor_enable_o,
  output logic                               audio_output_disable_o,
  output logic                               power_temp_ok_o
);

  // ****************************************************
  // Functions
  // ****************************************************
  // Pin owned by the status mux, not by its other role
  function automatic logic pin_free(
    input int          idx,
    input logic [15:0] ctl
  );
    logic free;
    free = 1'b0;
    case (idx)
      0:       free = ctl[tfe_pkg::CTL_PIN1_ROUTE];
      1:       free = ~ctl[tfe_pkg::CTL_CLK_SOURCE];
      2, 3, 4: free = ~ctl[tfe_pkg::CTL_IFACE_SEL];
      5:       free = ~ctl[tfe_pkg::CTL_PIN6_ROUTE];
      default: free = 1'b0;
    endcase
    return free;
  endfunction : pin_free

  function automatic logic is_status_func(input logic [3:0] sel);
    return (sel == tfe_pkg::FUNC_LOCK) || (sel == tfe_pkg::FUNC_TEMP);
  endfunction : is_status_func

  // ****************************************************
  // Registers
  // ****************************************************
  logic [15:0] status_reg;
  logic [15:0] status_next;
  logic [15:0] enable_reg;
  logic [15:0] enable_next;
  logic [15:0] polarity_reg;
  logic [15:0] polarity_next;
  logic [15:0] control_reg;
  logic [15:0] control_next;
  logic [15:0] sel_lo_reg;
  logic [15:0] sel_lo_next;
  logic [15:0] sel_hi_reg;
  logic [15:0] sel_hi_next;
  logic [15:0] pull_reg;
  logic [15:0] pull_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic        irq_reg;
  logic        irq_next;
  logic [5:0]  pin_out_reg;
  logic [5:0]  pin_out_next;
  logic [5:0]  pin_oe_reg;
  logic [5:0]  pin_oe_next;
  logic        audio_dis_reg;
  logic        audio_dis_next;
  logic        power_ok_reg;

  // ****************************************************
  // Address decode
  // ****************************************************
  wire hit_status   = (addr_i == tfe_pkg::EVENT_STATUS_ADDR);
  wire hit_enable   = (addr_i == tfe_pkg::EVENT_ENABLE_ADDR);
  wire hit_polarity = (addr_i == tfe_pkg::EVENT_POLARITY_ADDR);
  wire hit_control  = (addr_i == tfe_pkg::CONTROL_ADDR);
  wire hit_sel_lo   = (addr_i == tfe_pkg::PIN_SEL_LO_ADDR);
  wire hit_sel_hi   = (addr_i == tfe_pkg::PIN_SEL_HI_ADDR);
  wire hit_pull     = (addr_i == tfe_pkg::PIN_PULL_ADDR);

  wire wr_status   = wr_i & hit_status;
  wire wr_enable   = wr_i & hit_enable;
  wire wr_polarity = wr_i & hit_polarity;
  wire wr_control  = wr_i & hit_control;
  wire wr_sel_lo   = wr_i & hit_sel_lo;
  wire wr_sel_hi   = wr_i & hit_sel_hi;
  wire wr_pull     = wr_i & hit_pull;

  // ****************************************************
  // Control fields
  // ****************************************************
  wire thermal_sensor_enable =
    control_reg[tfe_pkg::CTL_SENSOR_ENA];
  wire thermal_output_disable =
    control_reg[tfe_pkg::CTL_OUT_DIS];
  wire audio_interface_tristate =
    control_reg[tfe_pkg::CTL_TRISTATE];
  wire pin_six_frame_clock_route =
    control_reg[tfe_pkg::CTL_PIN6_ROUTE];
  wire combined_event_invert =
    polarity_reg[tfe_pkg::INVERT_BIT];
  wire temperature_event_polarity =
    polarity_reg[tfe_pkg::TEMP_BIT];
  wire loop_lock_event_polarity =
    polarity_reg[tfe_pkg::LOCK_BIT];

  wire [23:0] pin_function_select = {sel_hi_reg[7:0], sel_lo_reg};
  wire [5:0]  pin_pull_up   = pull_reg[5:0];
  wire [5:0]  pin_pull_down = pull_reg[13:8];

  // ****************************************************
  // Event sources
  // ****************************************************
  // Disabled sensor reads as healthy, so it raises nothing while the temperature polarity bit is set
  wire temp_status =
    thermal_sensor_enable ? temp_ok_i : 1'b1;
  wire lock_status = loop_lock_i;

  wire temp_active =
    temp_status ^ temperature_event_polarity;
  wire lock_active = lock_status ^ loop_lock_event_polarity;

  wire [15:0] src_set = ({15'h0000, temp_active} << tfe_pkg::TEMP_BIT) |
                        ({15'h0000, lock_active} << tfe_pkg::LOCK_BIT);
  wire [15:0] clr_bits = wr_status ? (wdata_i & tfe_pkg::EVENT_MASK)
                                   : tfe_pkg::ZERO_WORD;

  // Level set applied after the clear, so set wins
  assign status_next =
    ((status_reg & ~clr_bits) | src_set) & tfe_pkg::EVENT_MASK;

  // ****************************************************
  // Writable registers
  // ****************************************************
  assign enable_next = wr_enable ? (wdata_i & tfe_pkg::EVENT_MASK)
                                 : enable_reg;
  assign polarity_next = wr_polarity ? (wdata_i & tfe_pkg::POLARITY_MASK)
                                     : polarity_reg;
  assign control_next = wr_control ? (wdata_i & tfe_pkg::CONTROL_MASK)
                                   : control_reg;
  assign sel_lo_next = wr_sel_lo ? wdata_i : sel_lo_reg;
  assign sel_hi_next = wr_sel_hi ? (wdata_i & tfe_pkg::SEL_HI_MASK)
                                 : sel_hi_reg;
  assign pull_next = wr_pull ? (wdata_i & tfe_pkg::PULL_MASK) : pull_reg;

  // ****************************************************
  // Combined event flag
  // ****************************************************
  wire combined_flag = |(status_reg & enable_reg);
  assign irq_next = combined_flag ^ combined_event_invert;

  // ****************************************************
  // Pin drive
  // ****************************************************
  // Status pins see raw status values, pin six frame clock is inverted; polarity bits never touch them
  genvar gp;
  generate
    for (gp = 0; gp < tfe_pkg::PIN_COUNT; gp++) begin : g_pin
      wire [3:0] sel = pin_function_select[gp*4 +: 4];
      wire own = pin_free(gp, control_reg) & ~audio_interface_tristate;
      wire stat = (sel == tfe_pkg::FUNC_TEMP) ? temp_status
                                              : lock_status;
      if (gp == tfe_pkg::PIN_COUNT - 1) begin : g_six
        wire frame = pin_six_frame_clock_route & ~audio_interface_tristate;
        assign pin_out_next[gp] = frame ? ~adc_frame_clock_i
                                        : (own & is_status_func(sel) & stat);
        assign pin_oe_next[gp] =
          frame | (own & is_status_func(sel));
      end else begin : g_other
        assign pin_out_next[gp] = own & is_status_func(sel) & stat;
        assign pin_oe_next[gp] = own & is_status_func(sel);
      end
    end
  endgenerate

  // ****************************************************
  // Thermal outputs
  // ****************************************************
  assign audio_dis_next = thermal_sensor_enable & thermal_output_disable &
                          ~temp_ok_i;

  // ****************************************************
  // Read mux
  // ****************************************************
  wire [15:0] status_view = status_reg |
                            ({15'h0000, combined_flag} << tfe_pkg::FLAG_BIT);
  wire [15:0] rd_value =
    hit_status   ? status_view  :
    hit_enable   ? enable_reg   :
    hit_polarity ? polarity_reg :
    hit_control  ? control_reg  :
    hit_sel_lo   ? sel_lo_reg   :
    hit_sel_hi   ? sel_hi_reg   :
    hit_pull     ? pull_reg     : tfe_pkg::ZERO_WORD;
  assign rdata_next = rd_i ? rd_value : tfe_pkg::ZERO_WORD;

  // ****************************************************
  // State
  // ****************************************************
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_reg   <= tfe_pkg::ZERO_WORD;
      enable_reg   <= tfe_pkg::ENABLE_RST;
      polarity_reg <= tfe_pkg::POLARITY_RST;
      control_reg  <= tfe_pkg::CONTROL_RST;
      sel_lo_reg   <= tfe_pkg::PIN_SEL_RST;
      sel_hi_reg   <= tfe_pkg::PIN_SEL_RST;
      pull_reg     <= tfe_pkg::PULL_RST;
    end else begin
      status_reg   <= status_next;
      enable_reg   <= enable_next;
      polarity_reg <= polarity_next;
      control_reg  <= control_next;
      sel_lo_reg   <= sel_lo_next;
      sel_hi_reg   <= sel_hi_next;
      pull_reg     <= pull_next;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg     <= tfe_pkg::ZERO_WORD;
      irq_reg       <= 1'b0;
      pin_out_reg   <= 6'h00;
      pin_oe_reg    <= 6'h00;
      audio_dis_reg <= 1'b0;
      power_ok_reg  <= 1'b1;
    end else begin
      rdata_reg     <= rdata_next;
      irq_reg       <= irq_next;
      pin_out_reg   <= pin_out_next;
      pin_oe_reg    <= pin_oe_next;
      audio_dis_reg <= audio_dis_next;
      power_ok_reg  <= temp_status;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign rdata_o                 = rdata_reg;
  assign irq_o                   = irq_reg;
  assign pin_out_o               = pin_out_reg;
  assign pin_oe_o                = pin_oe_reg;
  assign pin_pull_up_o           = pin_pull_up;
  assign pin_pull_down_o         = pin_pull_down;
  assign thermal_sensor_enable_o = thermal_sensor_enable;
  assign audio_output_disable_o  = audio_dis_reg;
  assign power_temp_ok_o         = power_ok_reg;

  // ****************************************************
  // Assertions
  // ****************************************************
  a_temp_event_set:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    temp_active |=> status_reg[tfe_pkg::TEMP_BIT])
  else $error("temperature event not latched");

  a_temp_event_hold:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (status_reg[tfe_pkg::TEMP_BIT] && !clr_bits[tfe_pkg::TEMP_BIT])
    |=> status_reg[tfe_pkg::TEMP_BIT])
  else $error("temperature event dropped without clear");

  a_lock_event_clear:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (clr_bits[tfe_pkg::LOCK_BIT] && !lock_active)
    |=> !status_reg[tfe_pkg::LOCK_BIT])
  else $error("lock event not cleared by write one");

  a_set_beats_clear:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (clr_bits[tfe_pkg::LOCK_BIT] && lock_active)
    |=> status_reg[tfe_pkg::LOCK_BIT])
  else $error("clear won over set");

  a_flag_or_enabled:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    ((status_reg & enable_reg) != 16'h0000 && !combined_event_invert)
    |=> irq_o)
  else $error("combined flag missing for enabled event");

  a_flag_inverted:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    ((status_reg & enable_reg) == 16'h0000 && combined_event_invert)
    |=> irq_o)
  else $error("inverted flag not high when idle");

  a_frame_clock_pin:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (pin_six_frame_clock_route && !audio_interface_tristate)
    |=> (pin_oe_o[5] && pin_out_o[5] == !$past(adc_frame_clock_i)))
  else $error("pin six not carrying inverted frame clock");

  a_temp_pin_raw:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (g_pin[2].sel == tfe_pkg::FUNC_TEMP && g_pin[2].own)
    |=> (pin_oe_o[2] && pin_out_o[2] == $past(temp_status)))
  else $error("pin three not showing temperature status");

  a_lock_pin_raw:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (g_pin[3].sel == tfe_pkg::FUNC_LOCK && g_pin[3].own)
    |=> (pin_oe_o[3] && pin_out_o[3] == $past(loop_lock_i)))
  else $error("pin four not showing lock status");

  a_audio_shutdown:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (thermal_sensor_enable && thermal_output_disable && !temp_ok_i)
    |=> audio_output_disable_o)
  else $error("audio outputs not disabled on over-temperature");

  a_sensor_quiet:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !thermal_sensor_enable |=> power_temp_ok_o)
  else $error("disabled sensor reported a status");

  a_lock_event_set:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    lock_active |=> status_reg[tfe_pkg::LOCK_BIT])
  else $error("lock event not latched");

  a_temp_event_clear:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (clr_bits[tfe_pkg::TEMP_BIT] && !temp_active)
    |=> !status_reg[tfe_pkg::TEMP_BIT])
  else $error("temperature event not cleared by write one");

  a_flag_drops:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    ((status_reg & enable_reg) == 16'h0000 && !combined_event_invert)
    |=> !irq_o)
  else $error("combined flag high with no enabled event");

  a_power_status:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    thermal_sensor_enable |=> (power_temp_ok_o == $past(temp_ok_i)))
  else $error("power path not following temperature status");

  a_audio_release:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !(thermal_sensor_enable && thermal_output_disable)
    |=> !audio_output_disable_o)
  else $error("audio disabled without both thermal enables");

  a_tristate_idle:
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    audio_interface_tristate |=> (pin_oe_o == 6'h00))
  else $error("pin driven while interface tristated");

endmodule : tfe_event_unit

// ### tfe_event_unit_tb.sv
`timescale 1ns/1ps

module tfe_event_unit_tb;
  logic        clock_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic        temp_ok, loop_lock, frame_clk;
  logic        temp_set = 1'b1;
  logic        lock_set = 1'b0;
  logic        frame_run = 1'b0;
  logic        irq_o, sens_ena, aud_dis, pwr_ok;
  logic [5:0]  pin_out, pin_oe, pull_up, pull_dn;
  logic        rd_q = 1'b0;
  logic        fc_prev = 1'b0;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h8C08;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles = 0;

  always #2 clock_i = ~clock_i;

  tfe_source_model u_src (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .temp_normal_i(temp_set), .locked_i(lock_set), .frame_run_i(frame_run),
    .temp_ok_o(temp_ok), .loop_lock_o(loop_lock), .frame_clock_o(frame_clk));

  tfe_event_unit u_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .temp_ok_i(temp_ok), .loop_lock_i(loop_lock),
    .adc_frame_clock_i(frame_clk), .irq_o(irq_o), .pin_out_o(pin_out),
    .pin_oe_o(pin_oe), .pin_pull_up_o(pull_up), .pin_pull_down_o(pull_dn),
    .thermal_sensor_enable_o(sens_ena), .audio_output_disable_o(aud_dis),
    .power_temp_ok_o(pwr_ok));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
  endfunction : lfsr

  task automatic chk(input string nm, input logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic conclude();
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask : wr

  // Expectation queued here, judged by the read monitor
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask : settle

  // ****************************************************
  // Monitors
  // ****************************************************
  always @(posedge clock_i) begin
    rd_q    <= rd_i;
    fc_prev <= frame_clk;
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end

  always @(negedge clock_i) begin
    if (rd_q === 1'b1) begin
      chk("rdata", exp_q.pop_front(), rdata_o);
    end
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    logic [15:0] v;
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    rd(8'h12, 16'h0000);
    rd(8'h16, 16'h0000);
    rd(8'h17, 16'h0800);
    rd(8'h20, 16'h0000);
    settle(1);
    chk("irq", 16'h0000, {15'h0, irq_o});
    chk("pwr", 16'h0001, {15'h0, pwr_ok});
    $display("test reset done");

    lock_set <= 1'b1;
    settle(4);
    rd(8'h12, 16'h0100);
    settle(0);
    chk("irq", 16'h0000, {15'h0, irq_o});
    wr(8'h16, 16'h0100);
    settle(2);
    chk("irq", 16'h0001, {15'h0, irq_o});
    wr(8'h12, 16'h0100);
    rd(8'h12, 16'h1100);
    lock_set <= 1'b0;
    settle(4);
    wr(8'h12, 16'h0100);
    rd(8'h12, 16'h0000);
    settle(1);
    chk("irq", 16'h0000, {15'h0, irq_o});
    $display("test lock done");

    wr(8'h17, 16'h0900);
    settle(3);
    rd(8'h12, 16'h1100);
    wr(8'h17, 16'h1900);
    settle(2);
    chk("irq", 16'h0000, {15'h0, irq_o});
    lock_set <= 1'b1;
    settle(4);
    wr(8'h12, 16'h0100);
    settle(3);
    chk("irq", 16'h0001, {15'h0, irq_o});
    rd(8'h12, 16'h0000);
    lock_set <= 1'b0;
    wr(8'h17, 16'h0800);
    settle(4);
    wr(8'h12, 16'h0100);
    wr(8'h16, 16'h0000);
    $display("test polarity done");

    temp_set <= 1'b0;
    settle(4);
    rd(8'h12, 16'h0000);
    wr(8'h40, 16'h0001);
    settle(3);
    chk("sens", 16'h0001, {15'h0, sens_ena});
    rd(8'h12, 16'h0800);
    settle(0);
    chk("pwr", 16'h0000, {15'h0, pwr_ok});
    chk("aud", 16'h0000, {15'h0, aud_dis});
    wr(8'h16, 16'h0800);
    settle(2);
    chk("irq", 16'h0001, {15'h0, irq_o});
    wr(8'h40, 16'h0003);
    settle(2);
    chk("aud", 16'h0001, {15'h0, aud_dis});
    temp_set <= 1'b1;
    settle(4);
    chk("aud", 16'h0000, {15'h0, aud_dis});
    wr(8'h12, 16'h0800);
    rd(8'h12, 16'h0000);
    $display("test temp done");

    wr(8'h40, 16'h0001);
    wr(8'h41, 16'h4504);
    for (int i = 0; i < 4; i++) begin
      temp_set <= i[0];
      lock_set <= i[1];
      wr(8'h17, i[0] ? 16'h0900 : 16'h0000);
      settle(4);
      chk("oe", 16'h000C, {10'h0, pin_oe});
      chk("pins", {14'h0, i[1:0]}, {14'h0, pin_out[3:2]});
    end
    wr(8'h40, 16'h0009);
    settle(2);
    chk("oe", 16'h000D, {10'h0, pin_oe});
    wr(8'h40, 16'h0049);
    settle(2);
    chk("oe", 16'h0001, {10'h0, pin_oe});
    wr(8'h40, 16'h000D);
    settle(2);
    chk("oe", 16'h0000, {10'h0, pin_oe});
    frame_run <= 1'b1;
    wr(8'h40, 16'h0011);
    settle(2);
    chk("oe6", 16'h0001, {15'h0, pin_oe[5]});
    repeat (12) begin
      settle(0);
      chk("pin6", {15'h0, ~fc_prev}, {15'h0, pin_out[5]});
      @(posedge clock_i);
    end
    frame_run <= 1'b0;
    $display("test pins done");

    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      v = seed[15:0];
      wr(8'h43, v);
      wr(8'h16, v);
      settle(1);
      chk("pull_up", {10'h0, v[5:0]}, {10'h0, pull_up});
      chk("pull_dn", {10'h0, v[13:8]}, {10'h0, pull_dn});
      rd(8'h43, v & tfe_pkg::PULL_MASK);
      rd(8'h16, v & tfe_pkg::EVENT_MASK);
    end
    settle(2);
    $display("test random done");
    conclude();
  end

endmodule : tfe_event_unit_tb

// ### tfe_pkg.sv
package tfe_pkg;

  // ****************************************************
  // Bus geometry
  // ****************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int PIN_COUNT = 6;
  localparam int SEL_W = 4;

  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [7:0] EVENT_STATUS_ADDR   = 8'h12;
  localparam logic [7:0] EVENT_ENABLE_ADDR   = 8'h16;
  localparam logic [7:0] EVENT_POLARITY_ADDR = 8'h17;
  localparam logic [7:0] CONTROL_ADDR        = 8'h40;
  localparam logic [7:0] PIN_SEL_LO_ADDR     = 8'h41;
  localparam logic [7:0] PIN_SEL_HI_ADDR     = 8'h42;
  localparam logic [7:0] PIN_PULL_ADDR       = 8'h43;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int LOCK_BIT   = 8;
  localparam int TEMP_BIT   = 11;
  localparam int FLAG_BIT   = 12;
  localparam int INVERT_BIT = 12;
  localparam int PULL_DN_LSB = 8;

  localparam int CTL_SENSOR_ENA = 0;
  localparam int CTL_OUT_DIS    = 1;
  localparam int CTL_TRISTATE   = 2;
  localparam int CTL_PIN1_ROUTE = 3;
  localparam int CTL_PIN6_ROUTE = 4;
  localparam int CTL_CLK_SOURCE = 5;
  localparam int CTL_IFACE_SEL  = 6;

  // ****************************************************
  // Masks and reset values
  // ****************************************************
  localparam logic [15:0] EVENT_MASK    = 16'h0900;
  localparam logic [15:0] POLARITY_MASK = 16'h1900;
  localparam logic [15:0] CONTROL_MASK  = 16'h007F;
  localparam logic [15:0] SEL_HI_MASK   = 16'h00FF;
  localparam logic [15:0] PULL_MASK     = 16'h3F3F;
  localparam logic [15:0] ENABLE_RST    = 16'h0000;
  localparam logic [15:0] POLARITY_RST  = 16'h0800;
  localparam logic [15:0] CONTROL_RST   = 16'h0000;
  localparam logic [15:0] PIN_SEL_RST   = 16'h0000;
  localparam logic [15:0] PULL_RST      = 16'h0000;
  localparam logic [15:0] ZERO_WORD     = 16'h0000;

  // ****************************************************
  // Pin function codes
  // ****************************************************
  localparam logic [3:0] FUNC_LOCK = 4'h4;
  localparam logic [3:0] FUNC_TEMP = 4'h5;

endpackage : tfe_pkg

// ### tfe_source_model.sv
`timescale 1ns/1ps

// ****************************************************
// Sensor, loop and frame clock sources
// ****************************************************
module tfe_source_model (
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  input  wire logic temp_normal_i,
  input  wire logic locked_i,
  input  wire logic frame_run_i,
  output logic      temp_ok_o,
  output logic      loop_lock_o,
  output logic      frame_clock_o
);
  logic [1:0] div_reg;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      temp_ok_o     <= 1'b1;
      loop_lock_o   <= 1'b0;
      div_reg       <= 2'h0;
      frame_clock_o <= 1'b0;
    end else begin
      temp_ok_o   <= temp_normal_i;
      loop_lock_o <= locked_i;
      // Odd divide so pin six cannot pass on a lucky phase
      div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
      if (frame_run_i && div_reg == 2'h2) begin
        frame_clock_o <= ~frame_clock_o;
      end
    end
  end

endmodule : tfe_source_model
